// ### shared/sbc_pkg.sv
// Purpose: Constants, types and timing for the SDRAM burst controller
// Assumes: 250 MHz system clock; SDRAM with 12-bit muxed address, 2 banks
// Notes:   Cycle counts are derived from times in their own units
package sbc_pkg;

  // ----------------------------------------------------------------
  // Clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_MHZ        = 250;
  localparam int PWRUP_US       = 100;
  localparam int PWRUP_CYC      = PWRUP_US * CLK_MHZ;
  localparam int REFRESH_NS     = 15600;
  // Longest interval, so round down
  localparam int REF_CYC        = (REFRESH_NS * CLK_MHZ) / 1000;
  localparam int T_RP_NS        = 20;
  localparam int T_RFC_NS       = 70;
  localparam int T_RCD_NS       = 20;
  localparam int T_MRD_NS       = 8;
  localparam int INIT_REFRESHES = 2;
  localparam int RD_LAT_CYC     = 6;
  localparam int WR_LAT_CYC     = 4;
  localparam int BURST_WORDS    = 256;

  // Least time in ns to whole cycles, at least one
  function automatic int cyc_ceil(input int ns);
    int c;
    c = (ns * CLK_MHZ + 999) / 1000;
    return (c < 1) ? 1 : c;
  endfunction

  localparam int T_RP_CYC  = cyc_ceil(T_RP_NS);
  localparam int T_RFC_CYC = cyc_ceil(T_RFC_NS);
  localparam int T_RCD_CYC = cyc_ceil(T_RCD_NS);
  localparam int T_MRD_CYC = cyc_ceil(T_MRD_NS);

  // ----------------------------------------------------------------
  // SDRAM address and mode word
  // ----------------------------------------------------------------
  localparam int         MA_W      = 12;
  localparam int         COL_W     = 8;
  localparam int         AP_BIT    = 10;
  localparam logic       MR_WBURST = 1'h0;
  localparam logic [2:0] MR_CAS    = 3'h2;
  localparam logic       MR_BTYPE  = 1'h0;
  localparam logic [2:0] MR_BLEN   = 3'h7;
  localparam logic [MA_W-1:0] MODE_WORD =
    {2'h0, MR_WBURST, 2'h0, MR_CAS, MR_BTYPE, MR_BLEN};

  // ----------------------------------------------------------------
  // Command pins: cs_n, ras_n, cas_n, we_n
  // ----------------------------------------------------------------
  typedef struct packed {
    logic cs_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
  } sbc_cmd_t;

  localparam sbc_cmd_t CMD_NOP   = 4'h7;
  localparam sbc_cmd_t CMD_ACT   = 4'h3;
  localparam sbc_cmd_t CMD_READ  = 4'h5;
  localparam sbc_cmd_t CMD_WRITE = 4'h4;
  localparam sbc_cmd_t CMD_PRE   = 4'h2;
  localparam sbc_cmd_t CMD_REF   = 4'h1;
  localparam sbc_cmd_t CMD_MRS   = 4'h0;

  typedef enum logic [2:0] {
    S_PWRUP, S_INIT_REF, S_WAIT, S_IDLE, S_BURST
  } sbc_state_t;

  // ----------------------------------------------------------------
  // APB register map
  // ----------------------------------------------------------------
  localparam logic [11:0] OFS_CTRL     = 12'h000;
  localparam logic [11:0] OFS_STATUS   = 12'h004;
  localparam logic [11:0] OFS_REFCNT   = 12'h008;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0001;
  localparam int          CTRL_REF_EN  = 0;
  localparam int          ST_INIT_DONE = 0;
  localparam int          ST_BURST     = 1;
  localparam int          ST_REF_DUE   = 2;
  localparam int          ST_STATE_LSB = 4;

endpackage

// ### verilog/sbc_sdram_ctrl.sv
// Purpose: Full-page burst SDRAM controller behind a PCI target back end
// Assumes: Front side logic shares clk; APB slave for control and status
// Notes:   Zero-wait APB; SDRAM data bus is split into in, out and enable
//
// Function
// - Address input width set by parameter, default 20
// - Read ready high when read access can start
// - Write ready high when write access can start
// - Wait 100 us with NOPs after reset
// - Then precharge all banks
// - Two auto refreshes before mode programming
// - Mode: burst write 0, CL2, sequential, full page
// - Begin with read qualifier starts burst read
// - Begin with write qualifier starts burst write
// - Burst continues until end pulse arrives
// - Auto refresh every 15.6 us
// - Ready rises cycle right after begin when idle with no refresh due, else once idle
// - Read word six cycles after strobe, then per strobe
// - Write word four cycles after strobe, then per strobe
// - End pulse terminates burst, precharges all banks
// - Works alongside target controller at its clock
// - Clock enable follows initiator ready during bursts
// - Asynchronous active-low reset returns initial state
`timescale 1ns/10ps
module sbc_sdram_ctrl
#(
  parameter int addr_width_param = 20,
  parameter int DATA_W           = 32,
  parameter int PWRUP_CYCLES     = sbc_pkg::PWRUP_CYC
) (
  // Clock and reset
  input  wire logic                        clk,
  input  wire logic                        resetn,
  // APB slave
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  // Front side command and handshake
  input  wire logic [addr_width_param-1:0] addr,
  input  wire logic                        xfer_begin_pulse,
  input  wire logic                        xfer_end_pulse,
  input  wire logic                        read_qualifier,
  input  wire logic                        write_qualifier,
  input  wire logic                        mem_space_qualifier,
  input  wire logic                        read_word_strobe,
  input  wire logic                        write_word_strobe,
  input  wire logic                        irdy_n,
  output logic                             read_side_ready,
  output logic                             write_side_ready,
  // Front side data
  input  wire logic [DATA_W-1:0]           wr_data,
  output logic      [DATA_W-1:0]           rd_data,
  output logic                             rd_data_valid,
  // SDRAM pins
  output sbc_pkg::sbc_cmd_t                mem_cmd,
  output logic                             mem_dqm,
  output logic      [sbc_pkg::MA_W-1:0]    muxed_row_col_addr,
  output logic                             mem_ba,
  output logic                             mem_cke,
  input  wire logic [DATA_W-1:0]           mem_dq_in,
  output logic      [DATA_W-1:0]           mem_dq_out,
  output logic                             mem_dq_oe
);
  import sbc_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  localparam int TMR_W = $clog2(PWRUP_CYCLES + 1);
  localparam int REF_W = $clog2(REF_CYC + 1);

  sbc_state_t            state_r, state_nxt, ret_r, ret_nxt;
  logic [TMR_W-1:0]      timer_r, timer_nxt;
  logic [1:0]            refleft_r, refleft_nxt;
  logic                  init_done_r, init_nxt;
  logic                  col_done_r, col_nxt;
  logic                  burst_rd_r, burst_rd_nxt;
  sbc_cmd_t              cmd_r, cmd_nxt;
  logic [MA_W-1:0]       ma_r, ma_nxt;
  logic                  ba_r, ba_nxt;
  logic                  cke_r, cke_nxt;
  logic                  dqm_r, oe_r;
  logic [DATA_W-1:0]     dq_out_r, dq_meta_r, dq_sync_r, rd_data_r;
  logic [RD_LAT_CYC-1:0] rd_pipe_r;
  logic [WR_LAT_CYC-1:0] wr_pipe_r;
  logic                  rd_rdy_r, wr_rdy_r;
  logic                  pend_r, pend_rd_r;
  logic [addr_width_param-1:0] addr_q_r;
  logic [REF_W-1:0]      ref_cnt_r;
  logic                  due_r, ref_taken;
  logic [31:0]           refs_r, ctrl_r, prdata_r;
  logic                  pslverr_r;

  // ----------------------------------------------------------------
  // Decode
  // ----------------------------------------------------------------
  // Begins before init completes are dropped, not queued
  wire begin_ok  = xfer_begin_pulse & mem_space_qualifier & init_done_r &
                   (read_qualifier | write_qualifier);
  wire ref_go    = due_r & ctrl_r[CTRL_REF_EN];
  wire in_idle   = (state_r == S_IDLE);
  wire in_burst  = (state_r == S_BURST);
  wire start_now = in_idle & ~ref_go & (begin_ok | pend_r);
  wire sel_rd    = begin_ok ? read_qualifier : pend_rd_r;
  wire [addr_width_param-1:0] sel_addr = begin_ok ? addr : addr_q_r;
  // Top address bit picks the bank, the rest split row and column
  wire [MA_W-1:0] row_addr = MA_W'(sel_addr[addr_width_param-2:COL_W]);
  wire [MA_W-1:0] col_addr = MA_W'(addr_q_r[COL_W-1:0]);
  wire [MA_W-1:0] ap_addr  = MA_W'(1) << AP_BIT;
  wire            wr_word  = wr_pipe_r[WR_LAT_CYC-1];
  wire            first_ok = burst_rd_r ? read_word_strobe : wr_word;
  wire            end_now  = in_burst & xfer_end_pulse;
  wire            ref_tick = init_done_r & (ref_cnt_r == '0);

  // ----------------------------------------------------------------
  // Sequencer next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt    = state_r;
    ret_nxt      = ret_r;
    timer_nxt    = (timer_r != '0) ? TMR_W'(timer_r - 1'b1) : timer_r;
    refleft_nxt  = refleft_r;
    init_nxt     = init_done_r;
    col_nxt      = col_done_r;
    burst_rd_nxt = burst_rd_r;
    cmd_nxt      = CMD_NOP;
    ma_nxt       = ma_r;
    ba_nxt       = ba_r;
    ref_taken    = 1'b0;
    case (state_r)
      S_PWRUP: begin
        if (timer_r == '0) begin
          cmd_nxt     = CMD_PRE;
          ma_nxt      = ap_addr;
          timer_nxt   = TMR_W'(T_RP_CYC - 1);
          ret_nxt     = S_INIT_REF;
          state_nxt   = S_WAIT;
          refleft_nxt = 2'(INIT_REFRESHES);
        end
      end
      S_INIT_REF: begin
        if (refleft_r != 2'h0) begin
          cmd_nxt     = CMD_REF;
          refleft_nxt = 2'(refleft_r - 2'h1);
          timer_nxt   = TMR_W'(T_RFC_CYC - 1);
          ret_nxt     = S_INIT_REF;
          state_nxt   = S_WAIT;
        end else begin
          cmd_nxt   = CMD_MRS;
          ma_nxt    = MODE_WORD;
          ba_nxt    = 1'b0;
          timer_nxt = TMR_W'(T_MRD_CYC - 1);
          ret_nxt   = S_IDLE;
          state_nxt = S_WAIT;
          init_nxt  = 1'b1;
        end
      end
      S_WAIT: begin
        if (timer_r == '0) begin
          state_nxt = ret_r;
        end
      end
      S_IDLE: begin
        if (ref_go) begin
          cmd_nxt   = CMD_REF;
          ref_taken = 1'b1;
          timer_nxt = TMR_W'(T_RFC_CYC - 1);
          ret_nxt   = S_IDLE;
          state_nxt = S_WAIT;
        end else if (start_now) begin
          cmd_nxt      = CMD_ACT;
          ma_nxt       = row_addr;
          ba_nxt       = sel_addr[addr_width_param-1];
          timer_nxt    = TMR_W'(T_RCD_CYC - 1);
          col_nxt      = 1'b0;
          burst_rd_nxt = sel_rd;
          state_nxt    = S_BURST;
        end
      end
      S_BURST: begin
        if (xfer_end_pulse) begin
          // Precharge also cuts a full-page burst short
          cmd_nxt   = CMD_PRE;
          ma_nxt    = ap_addr;
          timer_nxt = TMR_W'(T_RP_CYC - 1);
          ret_nxt   = S_IDLE;
          state_nxt = S_WAIT;
        end else if (!col_done_r && timer_r == '0 && first_ok) begin
          // One column command; the page then streams on its own
          cmd_nxt = burst_rd_r ? CMD_READ : CMD_WRITE;
          ma_nxt  = col_addr;
          col_nxt = 1'b1;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
  end

  // Clock enable: stall the SDRAM while the PCI master waits
  always_comb begin
    cke_nxt = 1'b1;
    if (in_burst && col_done_r && !xfer_end_pulse) begin
      cke_nxt = ~irdy_n;
    end
  end

  // ----------------------------------------------------------------
  // Sequencer registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_r     <= S_PWRUP;
      ret_r       <= S_PWRUP;
      timer_r     <= TMR_W'(PWRUP_CYCLES - 1);
      refleft_r   <= 2'h0;
      init_done_r <= 1'b0;
      col_done_r  <= 1'b0;
      burst_rd_r  <= 1'b0;
    end else begin
      state_r     <= state_nxt;
      ret_r       <= ret_nxt;
      timer_r     <= timer_nxt;
      refleft_r   <= refleft_nxt;
      init_done_r <= init_nxt;
      col_done_r  <= col_nxt;
      burst_rd_r  <= burst_rd_nxt;
    end
  end

  // SDRAM pin registers
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      cmd_r <= CMD_NOP;
      ma_r  <= '0;
      ba_r  <= 1'b0;
      cke_r <= 1'b1;
    end else begin
      cmd_r <= cmd_nxt;
      ma_r  <= ma_nxt;
      ba_r  <= ba_nxt;
      cke_r <= cke_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Begin capture and ready handshake
  // ----------------------------------------------------------------
  // A begin during refresh is held and served once idle
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      pend_r    <= 1'b0;
      pend_rd_r <= 1'b0;
      addr_q_r  <= '0;
    end else begin
      pend_r <= (begin_ok | pend_r) & ~start_now;
      if (begin_ok) begin
        pend_rd_r <= read_qualifier;
        addr_q_r  <= addr;
      end
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_rdy_r <= 1'b0;
      wr_rdy_r <= 1'b0;
    end else if (end_now) begin
      rd_rdy_r <= 1'b0;
      wr_rdy_r <= 1'b0;
    end else if (start_now) begin
      rd_rdy_r <= sel_rd;
      wr_rdy_r <= ~sel_rd;
    end
  end

  // ----------------------------------------------------------------
  // Data path
  // ----------------------------------------------------------------
  // Strobe delay lines mark when words are due
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rd_pipe_r <= '0;
      wr_pipe_r <= '0;
    end else begin
      rd_pipe_r <= {rd_pipe_r[RD_LAT_CYC-2:0], read_word_strobe & in_burst};
      wr_pipe_r <= {wr_pipe_r[WR_LAT_CYC-2:0], write_word_strobe & in_burst};
    end
  end

  // Read pins pass three flops; the command register and the CAS latency fill the rest
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      dq_meta_r <= '0;
      dq_sync_r <= '0;
      rd_data_r <= '0;
      dq_out_r  <= '0;
      oe_r      <= 1'b0;
      dqm_r     <= 1'b0;
    end else begin
      dq_meta_r <= mem_dq_in;
      dq_sync_r <= dq_meta_r;
      rd_data_r <= dq_sync_r;
      dq_out_r  <= wr_data;
      oe_r      <= in_burst & ~burst_rd_r & ~xfer_end_pulse;
      // Masks write slots with no word from the front side
      dqm_r     <= in_burst & ~burst_rd_r & ~wr_word;
    end
  end

  // ----------------------------------------------------------------
  // Refresh timer
  // ----------------------------------------------------------------
  // Set wins over take, so a tick never gets lost
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ref_cnt_r <= REF_W'(REF_CYC - 1);
      due_r     <= 1'b0;
      refs_r    <= 32'h0000_0000;
    end else begin
      if (init_done_r) begin
        ref_cnt_r <= ref_tick ? REF_W'(REF_CYC - 1) : REF_W'(ref_cnt_r - 1'b1);
      end
      due_r <= ref_tick | (due_r & ~ref_taken);
      if (ref_taken) begin
        refs_r <= refs_r + 32'h0000_0001;
      end
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  wire apb_setup = psel & ~penable;
  wire apb_wr    = psel & penable & pwrite;
  wire hit_ctrl  = (paddr == OFS_CTRL);
  wire hit_stat  = (paddr == OFS_STATUS);
  wire hit_refs  = (paddr == OFS_REFCNT);
  wire [31:0] status_w = (32'(state_r) << ST_STATE_LSB) |
                         (32'(due_r) << ST_REF_DUE) |
                         (32'(in_burst) << ST_BURST) |
                         (32'(init_done_r) << ST_INIT_DONE);
  wire [31:0] rd_mux = hit_ctrl ? ctrl_r :
                       hit_stat ? status_w :
                       hit_refs ? refs_r : 32'h0000_0000;

  // Read data fixed at setup so the access phase needs no wait
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_r    <= CTRL_RST;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      if (apb_setup) begin
        prdata_r  <= rd_mux;
        pslverr_r <= ~(hit_ctrl | hit_stat | hit_refs);
      end
      if (apb_wr && hit_ctrl) begin
        ctrl_r <= pwdata & (32'h0000_0001 << CTRL_REF_EN);
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign prdata             = prdata_r;
  assign pready             = 1'b1;
  assign pslverr            = pslverr_r;
  assign read_side_ready    = rd_rdy_r;
  assign write_side_ready   = wr_rdy_r;
  assign rd_data            = rd_data_r;
  assign rd_data_valid      = rd_pipe_r[RD_LAT_CYC-1];
  assign mem_cmd            = cmd_r;
  assign mem_dqm            = dqm_r;
  assign muxed_row_col_addr = ma_r;
  assign mem_ba             = ba_r;
  assign mem_cke            = cke_r;
  assign mem_dq_out         = dq_out_r;
  assign mem_dq_oe          = oe_r;

endmodule

// ### sim/sbc_sdram_model.sv
// Purpose: Behavioural SDRAM device facing the burst controller
// Assumes: CAS latency 2, full-page bursts wrap inside the open row
// Notes:   Idle data lines toggle so a stale value never reads as valid
`timescale 1ns/10ps
module sbc_sdram_model (
  // Clock
  input  wire logic              clk,
  // Command, address and clock enable
  input  wire sbc_pkg::sbc_cmd_t mem_cmd,
  input  wire logic [11:0]       muxed_row_col_addr,
  input  wire logic              mem_ba,
  input  wire logic              mem_cke,
  // Data
  input  wire logic              mem_dqm,
  input  wire logic [31:0]       mem_dq_out,
  input  wire logic              mem_dq_oe,
  output logic      [31:0]       mem_dq_in
);
  import sbc_pkg::*;
  logic [31:0] cells [int];
  logic [10:0] row_r = 11'h000;
  logic [7:0]  col_r = 8'h00;
  logic        rd_r  = 1'b0;
  logic        wr_r  = 1'b0;
  logic        cmd_col;
  int          k;
  initial mem_dq_in = 32'h0000_0000;
  assign cmd_col = (mem_cmd == CMD_READ) || (mem_cmd == CMD_WRITE);
  // Low clock enable freezes the column pointer, as a real part would
  always @(posedge clk) begin
    k = {mem_ba, row_r, col_r};
    if (mem_cmd == CMD_ACT)
      row_r <= muxed_row_col_addr[10:0];
    if (mem_cmd == CMD_WRITE && mem_dq_oe && !mem_dqm)
      cells[{mem_ba, row_r, muxed_row_col_addr[7:0]}] = mem_dq_out;
    if (wr_r && mem_cke && mem_dq_oe && !mem_dqm)
      cells[k] = mem_dq_out;
    if (rd_r && mem_cke && cells.exists(k))
      mem_dq_in <= cells[k];
    else
      mem_dq_in <= ~mem_dq_in;
    if (cmd_col) begin
      col_r <= muxed_row_col_addr[7:0] + {7'h00, mem_cmd == CMD_WRITE};
      rd_r  <= (mem_cmd == CMD_READ);
      wr_r  <= (mem_cmd == CMD_WRITE);
    end else if (mem_cmd != CMD_NOP) begin
      rd_r <= 1'b0;
      wr_r <= 1'b0;
    end else if (mem_cke && (rd_r || wr_r))
      col_r <= col_r + 8'h01;
  end
endmodule

// ### sim/sbc_ctrl_chk_asserts.sv
// Purpose: Port-level checks of the burst controller
// Assumes: One clock domain, asynchronous active-low reset
// Notes:   Long waits are counted in helper registers
`timescale 1ns/10ps
module sbc_ctrl_chk #(
  parameter int PWRUP_CYCLES = 50
) (
  // Clock and reset
  input wire logic              clk,
  input wire logic              resetn,
  // Front side
  input wire logic              xfer_begin_pulse,
  input wire logic              xfer_end_pulse,
  input wire logic              read_qualifier,
  input wire logic              write_qualifier,
  input wire logic              mem_space_qualifier,
  input wire logic              read_word_strobe,
  input wire logic              irdy_n,
  input wire logic              read_side_ready,
  input wire logic              write_side_ready,
  input wire logic              rd_data_valid,
  // Memory side
  input wire sbc_pkg::sbc_cmd_t mem_cmd,
  input wire logic [11:0]       muxed_row_col_addr,
  input wire logic              mem_ba,
  input wire logic              mem_cke
);
  import sbc_pkg::*;
  // Slack covers a burst holding off a due refresh
  localparam int REF_LIM = REF_CYC + 400;
  logic [15:0] up_cnt_r;
  logic [12:0] gap_r;
  logic [1:0]  ref_cnt_r;
  logic        seen_r, init_r, col_r, is_col, rdy;
  assign is_col = (mem_cmd == CMD_READ) || (mem_cmd == CMD_WRITE);
  assign rdy    = read_side_ready || write_side_ready;
  // ----------------
  // Helper history
  // ----------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      up_cnt_r  <= 16'h0000;
      gap_r     <= 13'h0000;
      ref_cnt_r <= 2'h0;
      seen_r    <= 1'b0;
      init_r    <= 1'b0;
      col_r     <= 1'b0;
    end else begin
      up_cnt_r  <= up_cnt_r + {15'h0000, ~&up_cnt_r};
      gap_r     <= (mem_cmd == CMD_REF) ? 13'h0000 : gap_r + 13'h0001;
      ref_cnt_r <= ref_cnt_r + {1'b0, (mem_cmd == CMD_REF) && !init_r};
      seen_r    <= seen_r | (mem_cmd != CMD_NOP);
      init_r    <= init_r | (mem_cmd == CMD_MRS);
      col_r     <= is_col | (col_r & (mem_cmd != CMD_PRE));
    end
  end
  // ----------------
  // Properties
  // ----------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  property p_pwrup; up_cnt_r < PWRUP_CYCLES |-> mem_cmd == CMD_NOP; endproperty
  a_pwrup: assert property (p_pwrup) else $error("command during power-up wait");
  property p_first; !seen_r && mem_cmd != CMD_NOP |-> mem_cmd == CMD_PRE
    && muxed_row_col_addr[AP_BIT]; endproperty
  a_first: assert property (p_first) else $error("first command not precharge all");
  property p_two_ref; mem_cmd == CMD_MRS && !init_r |-> ref_cnt_r == 2'h2; endproperty
  a_two_ref: assert property (p_two_ref) else $error("refresh count before mode");
  property p_mode; mem_cmd == CMD_MRS |-> muxed_row_col_addr == MODE_WORD && !mem_ba; endproperty
  a_mode: assert property (p_mode) else $error("mode word differs");
  property p_no_rdy; !init_r |-> !rdy; endproperty
  a_no_rdy: assert property (p_no_rdy) else $error("ready before init");
  property p_begin; init_r && xfer_begin_pulse && mem_space_qualifier && !rdy
    && (read_qualifier || write_qualifier) |-> ##[1:40] rdy; endproperty
  a_begin: assert property (p_begin) else $error("begin not answered");
  property p_hold; read_side_ready && !xfer_end_pulse |=> read_side_ready; endproperty
  a_hold: assert property (p_hold) else $error("read ready dropped early");
  property p_end; rdy && xfer_end_pulse |=> mem_cmd == CMD_PRE
    && muxed_row_col_addr[AP_BIT] && !rdy; endproperty
  a_end: assert property (p_end) else $error("end not followed by precharge");
  property p_rd_lat; read_side_ready && read_word_strobe |-> ##6 rd_data_valid; endproperty
  a_rd_lat: assert property (p_rd_lat) else $error("read word late");
  property p_ref; init_r |-> gap_r < REF_LIM; endproperty
  a_ref: assert property (p_ref) else $error("refresh overdue");
  property p_cke; col_r && mem_cmd != CMD_PRE && !xfer_end_pulse |=> mem_cke == !$past(irdy_n);
  endproperty
  a_cke: assert property (p_cke) else $error("clock enable ignores initiator");
endmodule

// ### sim/tb_sdram_burst_controller.sv
// Purpose: Self-checking bench for the SDRAM burst controller
// Assumes: Shortened power-up wait, refresh period from the package
// Notes:   Expected data comes from a bench-side memory image
`timescale 1ns/10ps
module tb_sdram_burst_controller;
  import sbc_pkg::*;
  localparam int PWR = 50;
  logic clk = 1'b0, resetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0000_0000, prdata, rd_data, mem_dq_in, mem_dq_out, v;
  logic [31:0] wr_data = 32'h0000_0000, lfsr = 32'h0000_0031;
  logic [19:0] addr = 20'h0_0000;
  logic xfer_begin_pulse = 1'b0, xfer_end_pulse = 1'b0, read_qualifier = 1'b0;
  logic write_qualifier = 1'b0, mem_space_qualifier = 1'b0, irdy_n = 1'b0;
  logic read_word_strobe = 1'b0, write_word_strobe = 1'b0, pready, pslverr, e;
  logic read_side_ready, write_side_ready, rd_data_valid, mem_dqm, mem_ba, mem_cke, mem_dq_oe;
  logic [11:0] muxed_row_col_addr;
  sbc_cmd_t    mem_cmd;
  logic [31:0] img [int];
  int          err_total = 0, total_checks = 0;
  always #2 clk = ~clk;
  sbc_sdram_ctrl #(.PWRUP_CYCLES(PWR)) u_dut (.*);
  sbc_sdram_model u_mem (.*);
  // ----------------
  // Shared tasks
  // ----------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic test_done;
    $display("checks=%0d mismatches=%0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // Next word of the stimulus sequence
  function automatic logic [31:0] lfsr_step(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // Request held from setup until pready is seen high; only the watchdog ends a wait
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d = 32'h0000_0000);
    @(posedge clk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge clk);
    penable <= 1'b1;
    do @(posedge clk); while (pready !== 1'b1);
    v = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic poke(input logic mq);
    @(posedge clk);
    {xfer_begin_pulse, read_qualifier, mem_space_qualifier} <= {2'b11, mq};
    @(posedge clk);
    xfer_begin_pulse <= 1'b0;
    repeat (10) @(posedge clk);
    check(read_side_ready, 1'b0);
  endtask
  // Begin, strobed words, initiator stall, end; n stays within one page
  task automatic burst(input logic w, input logic [19:0] a, input int n);
    int i, t;
    @(posedge clk);
    {addr, xfer_begin_pulse, read_qualifier, write_qualifier} <= {a, 1'b1, !w, w};
    @(posedge clk);
    xfer_begin_pulse <= 1'b0;
    #1;
    for (t = 0; t < 40 && (w ? write_side_ready : read_side_ready) !== 1'b1; t++)
      @(posedge clk);
    check(w ? write_side_ready : read_side_ready, 1'b1);
    repeat (5) @(posedge clk);
    for (i = 0; i < n + 8; i++) begin
      @(posedge clk);
      if (w) write_word_strobe <= (i < n);
      else read_word_strobe <= (i < n);
      if (w && i >= 4 && i < n + 4) begin
        lfsr = lfsr_step(lfsr);
        img[{a[19:8], a[7:0] + 8'(i - 4)}] = lfsr;
        wr_data <= lfsr;
      end
      #1;
      if (!w) check(rd_data_valid, i >= 6 && i < n + 6);
      if (!w && i >= 6 && i < n + 6) check(rd_data, img[{a[19:8], a[7:0] + 8'(i - 6)}]);
    end
    irdy_n <= 1'b1;
    repeat (3) @(posedge clk);
    irdy_n <= 1'b0;
    #1 check(mem_cke, 1'b0);
    @(posedge clk);
    xfer_end_pulse <= 1'b1;
    @(posedge clk);
    xfer_end_pulse <= 1'b0;
    #1 check(32'(mem_cmd), 32'(CMD_PRE));
    check(w ? write_side_ready : read_side_ready, 1'b0);
    repeat (7) @(posedge clk);
  endtask
  // ----------------
  // Main sequence and watchdog
  // ----------------
  initial begin
    #120000;
    err_total++;
    test_done;
  end
  initial begin
    logic [31:0] r0;
    repeat (5) @(posedge clk);
    resetn <= 1'b1;
    poke(1'b1);
    apb(1'b0, OFS_CTRL);
    check(v, CTRL_RST);
    apb(1'b0, 12'h00C);
    check({v[30:0], e}, 32'h0000_0001);
    for (int n = 0; n < 100 && v[ST_INIT_DONE] !== 1'b1; n++)
      apb(1'b0, OFS_STATUS);
    check(v[ST_INIT_DONE], 1'b1);
    apb(1'b1, OFS_CTRL);
    apb(1'b0, OFS_CTRL);
    check(v, 32'h0000_0000);
    apb(1'b1, OFS_CTRL, 32'h0000_0001);
    poke(1'b0);
    mem_space_qualifier <= 1'b1;
    // Fixed address: the write's own data advances the sequence
    burst(1'b1, 20'h0_0031, 3);
    burst(1'b0, 20'h0_0031, 3);
    burst(1'b1, 20'h8_1200, 256);
    burst(1'b0, 20'h8_1200, 256);
    apb(1'b0, OFS_REFCNT);
    r0 = v;
    repeat (4000) @(posedge clk);
    apb(1'b0, OFS_REFCNT);
    check(v - r0 == 32'd1 || v - r0 == 32'd2, 1'b1);
    burst(1'b0, 20'h8_1200, 40);
    @(posedge clk);
    resetn <= 1'b0;
    #1 check({mem_cmd, read_side_ready}, {CMD_NOP, 1'b0});
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, OFS_STATUS);
    check(v[ST_INIT_DONE], 1'b0);
    test_done;
  end
endmodule
bind sbc_sdram_ctrl sbc_ctrl_chk #(.PWRUP_CYCLES(PWRUP_CYCLES)) u_chk (.*);
